// [hdl/sfr_read_engine.sv]
`timescale 1ns/100ps
module sfr_read_engine #(
   parameter int ADDR_W = 24
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic [3:0] i_io_in,
   output logic [3:0] o_io_out,
   output logic [3:0] o_io_oe_n,
   input wire logic i_write_busy,
   input wire logic i_four_line_command_mode,
   input wire logic i_quad_enable_bit,
   input wire logic [7:0] i_config_reg,
   output logic o_mem_req,
   output logic [ADDR_W-1:0] o_mem_addr,
   input wire logic i_mem_gnt,
   input wire logic i_mem_valid,
   input wire logic [7:0] i_mem_data,
   output logic o_mem_ready
);

   function automatic sfr_pkg::sfr_cmd_type decode(input logic [7:0] op, input logic four_line,
                                                   input logic quad_en, input logic dc_low);
      sfr_pkg::sfr_cmd_type c;
      c = '0;
      c.addr_lanes = sfr_pkg::LANES_1;
      c.data_lanes = sfr_pkg::LANES_1;
      if (four_line) begin
         if (op == sfr_pkg::OP_FAST_READ) begin
            c.ok = 1'b1;
            c.addr_lanes = sfr_pkg::LANES_4;
            c.data_lanes = sfr_pkg::LANES_4;
            c.dummy = sfr_pkg::DUMMY_FOUR_LINE;
         end
      end else begin
         case (op)
            sfr_pkg::OP_READ: begin
               c.ok = 1'b1;
               c.dummy = sfr_pkg::DUMMY_NONE;
            end
            sfr_pkg::OP_FAST_READ: begin
               c.ok = 1'b1;
               c.dummy = sfr_pkg::DUMMY_SINGLE;
            end
            sfr_pkg::OP_DUAL_OUTPUT_READ: begin
               c.ok = 1'b1;
               c.data_lanes = sfr_pkg::LANES_2;
               c.dummy = sfr_pkg::DUMMY_SINGLE;
            end
            sfr_pkg::OP_DUAL_IO_READ: begin
               c.ok = 1'b1;
               c.addr_lanes = sfr_pkg::LANES_2;
               c.data_lanes = sfr_pkg::LANES_2;
               c.dummy = dc_low ? sfr_pkg::DUMMY_DUAL_IO_LONG : sfr_pkg::DUMMY_DUAL_IO_SHORT;
            end
            sfr_pkg::OP_QUAD_OUTPUT_READ: begin
               c.ok = quad_en;
               c.data_lanes = sfr_pkg::LANES_4;
               c.dummy = sfr_pkg::DUMMY_SINGLE;
            end
            default: c.ok = 1'b0;
         endcase
      end
      return c;
   endfunction : decode

   function automatic logic [4:0] addr_cycles(input logic [2:0] lanes);
      logic [4:0] n;
      n = 5'(sfr_pkg::ADDR_BITS);
      if (lanes == sfr_pkg::LANES_4) n = 5'(sfr_pkg::ADDR_BITS / 4);
      else if (lanes == sfr_pkg::LANES_2) n = 5'(sfr_pkg::ADDR_BITS / 2);
      return n;
   endfunction : addr_cycles

   function automatic logic [23:0] shift_in(input logic [23:0] v, input logic [2:0] lanes, input logic [3:0] io);
      logic [23:0] r;
      r = {v[22:0], io[0]};
      if (lanes == sfr_pkg::LANES_4) r = {v[19:0], io};
      else if (lanes == sfr_pkg::LANES_2) r = {v[21:0], io[1:0]};
      return r;
   endfunction : shift_in

   // Synchronisers for everything arriving from the link
   logic sclk_m, sclk_s, sclk_d, cs_m, cs_s;
   logic [3:0] io_m, io_s;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         sclk_m <= 1'b0;
         sclk_s <= 1'b0;
         sclk_d <= 1'b0;
         cs_m <= 1'b1;
         cs_s <= 1'b1;
         io_m <= 4'h0;
         io_s <= 4'h0;
      end else begin
         sclk_m <= i_sclk;
         sclk_s <= sclk_m;
         sclk_d <= sclk_s;
         cs_m <= i_cs_n;
         cs_s <= cs_m;
         io_m <= i_io_in;
         io_s <= io_m;
      end
   end

   logic sclk_rise, sclk_fall;
   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;

   // Command sequencer
   sfr_pkg::sfr_state_type state, next_state;
   sfr_pkg::sfr_cmd_type cmd, next_cmd;
   logic [4:0] cnt, next_cnt;
   logic [7:0] op, next_op;
   logic [23:0] rx_addr, next_rx_addr;
   logic [7:0] sh, next_sh;
   logic [3:0] bits, next_bits;
   logic [3:0] io_out, next_io_out;
   logic [3:0] oe_n, next_oe_n;
   logic load_addr, pop;

   // Two-entry buffer and fetch state
   logic [7:0] buf_mem [2];
   logic [7:0] next_buf_mem [2];
   logic wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic [1:0] count, next_count;
   logic req, next_req, pend, next_pend, mem_ready, next_mem_ready;
   logic [ADDR_W-1:0] mem_addr, next_mem_addr;
   logic fetch_on, push;

   always_comb begin
      sfr_pkg::sfr_cmd_type d;
      logic [7:0] cur;
      logic [4:0] op_len;
      d = '0;
      cur = sh;
      op_len = i_four_line_command_mode ? sfr_pkg::FOUR_LINE_OPCODE_CYCLES : sfr_pkg::SPI_OPCODE_CYCLES;
      next_state = state;
      next_cmd = cmd;
      next_cnt = cnt;
      next_op = op;
      next_rx_addr = rx_addr;
      next_sh = sh;
      next_bits = bits;
      next_io_out = io_out;
      next_oe_n = oe_n;
      load_addr = 1'b0;
      pop = 1'b0;
      if (cs_s) begin
         next_state = sfr_pkg::ST_OPCODE;
         next_cnt = 5'h00;
         next_bits = 4'h0;
         next_oe_n = 4'hF;
      end else begin
         case (state)
            sfr_pkg::ST_OPCODE: begin
               if (sclk_rise) begin
                  next_op = i_four_line_command_mode ? {op[3:0], io_s} : {op[6:0], io_s[0]};
                  next_cnt = cnt + 5'h01;
                  if (next_cnt == op_len) begin
                     d = decode(next_op, i_four_line_command_mode, i_quad_enable_bit,
                                i_config_reg[sfr_pkg::DUMMY_COUNT_BIT_LOW_POS]);
                     next_cmd = d;
                     next_cnt = 5'h00;
                     next_state = (d.ok && !i_write_busy) ? sfr_pkg::ST_ADDR : sfr_pkg::ST_IGNORE;
                  end
               end
            end
            sfr_pkg::ST_ADDR: begin
               if (sclk_rise) begin
                  next_rx_addr = shift_in(rx_addr, cmd.addr_lanes, io_s);
                  next_cnt = cnt + 5'h01;
                  if (next_cnt == addr_cycles(cmd.addr_lanes)) begin
                     load_addr = 1'b1;
                     next_cnt = 5'h00;
                     next_state = (cmd.dummy == sfr_pkg::DUMMY_NONE) ? sfr_pkg::ST_DATA : sfr_pkg::ST_DUMMY;
                  end
               end
            end
            sfr_pkg::ST_DUMMY: begin
               if (sclk_rise) begin
                  next_cnt = cnt + 5'h01;
                  if (next_cnt == 5'(cmd.dummy)) begin
                     next_cnt = 5'h00;
                     next_state = sfr_pkg::ST_DATA;
                  end
               end
            end
            sfr_pkg::ST_DATA: begin
               if (sclk_fall) begin
                  if (bits == 4'h0) begin
                     cur = (count != 2'h0) ? buf_mem[rd_ptr] : 8'h00;
                     pop = (count != 2'h0);
                  end
                  case (cmd.data_lanes)
                     sfr_pkg::LANES_4: begin
                        next_io_out = cur[7:4];
                        next_oe_n = 4'h0;
                     end
                     sfr_pkg::LANES_2: begin
                        next_io_out = {2'b00, cur[7:6]};
                        next_oe_n = 4'hC;
                     end
                     default: begin
                        next_io_out = {2'b00, cur[7], 1'b0};
                        next_oe_n = 4'hD;
                     end
                  endcase
                  next_sh = cur << cmd.data_lanes;
                  next_bits = ((bits == 4'h0) ? sfr_pkg::BYTE_BITS : bits) - {1'b0, cmd.data_lanes};
               end
            end
            sfr_pkg::ST_IGNORE: next_state = sfr_pkg::ST_IGNORE;
            default: next_state = sfr_pkg::ST_OPCODE;
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state <= sfr_pkg::ST_OPCODE;
         cmd <= '0;
         cnt <= 5'h00;
         op <= 8'h00;
         rx_addr <= '0;
         sh <= 8'h00;
         bits <= 4'h0;
         io_out <= 4'h0;
         oe_n <= 4'hF;
      end else begin
         state <= next_state;
         cmd <= next_cmd;
         cnt <= next_cnt;
         op <= next_op;
         rx_addr <= next_rx_addr;
         sh <= next_sh;
         bits <= next_bits;
         io_out <= next_io_out;
         oe_n <= next_oe_n;
      end
   end

   // Prefetch: one request in flight, never more than the buffer can hold
   assign fetch_on = !cs_s && (state == sfr_pkg::ST_DUMMY || state == sfr_pkg::ST_DATA);
   assign push = i_mem_valid && mem_ready && pend && fetch_on;

   always_comb begin
      next_mem_addr = mem_addr;
      next_req = req;
      next_pend = pend;
      next_buf_mem = buf_mem;
      next_wr_ptr = wr_ptr;
      next_rd_ptr = rd_ptr;
      next_count = count;
      if (load_addr) begin
         next_mem_addr = next_rx_addr[ADDR_W-1:0];
      end else if (req && i_mem_gnt) begin
         next_req = 1'b0;
         next_pend = 1'b1;
         next_mem_addr = mem_addr + ADDR_W'(1);
      end else if (!req && !pend && fetch_on && count < sfr_pkg::BUF_DEPTH) begin
         next_req = 1'b1;
      end
      if (i_mem_valid && mem_ready && pend) next_pend = 1'b0;
      if (!fetch_on) begin
         next_count = 2'h0;
         next_wr_ptr = 1'b0;
         next_rd_ptr = 1'b0;
      end else begin
         if (push) begin
            next_buf_mem[wr_ptr] = i_mem_data;
            next_wr_ptr = ~wr_ptr;
         end
         if (pop) next_rd_ptr = ~rd_ptr;
         next_count = count + {1'b0, push} - {1'b0, pop};
      end
      next_mem_ready = next_count < sfr_pkg::BUF_DEPTH;
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         mem_addr <= '0;
         req <= 1'b0;
         pend <= 1'b0;
         buf_mem[0] <= 8'h00;
         buf_mem[1] <= 8'h00;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         count <= 2'h0;
         mem_ready <= 1'b1;
      end else begin
         mem_addr <= next_mem_addr;
         req <= next_req;
         pend <= next_pend;
         buf_mem <= next_buf_mem;
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
         count <= next_count;
         mem_ready <= next_mem_ready;
      end
   end

   assign o_io_out = io_out;
   assign o_io_oe_n = oe_n;
   assign o_mem_req = req;
   assign o_mem_addr = mem_addr;
   assign o_mem_ready = mem_ready;

endmodule : sfr_read_engine

// [shared/sfr_pkg.sv]
package sfr_pkg;

   // Command opcodes as seen on the wire
   localparam logic [7:0] OP_READ = 8'h03;
   localparam logic [7:0] OP_FAST_READ = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUTPUT_READ = 8'h3B;
   localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
   localparam logic [7:0] OP_QUAD_OUTPUT_READ = 8'h6B;

   // Phase lengths in serial clocks, address length in bits
   localparam logic [4:0] SPI_OPCODE_CYCLES = 5'h08;
   localparam logic [4:0] FOUR_LINE_OPCODE_CYCLES = 5'h02;
   localparam int ADDR_BITS = 24;
   localparam logic [3:0] DUMMY_NONE = 4'h0;
   localparam logic [3:0] DUMMY_SINGLE = 4'h8;
   localparam logic [3:0] DUMMY_FOUR_LINE = 4'h4;
   localparam logic [3:0] DUMMY_DUAL_IO_SHORT = 4'h4;
   localparam logic [3:0] DUMMY_DUAL_IO_LONG = 4'h8;

   // Configuration register dummy-count field
   localparam int DUMMY_COUNT_BIT_LOW_POS = 6;
   localparam int DUMMY_COUNT_BIT_HIGH_POS = 7;

   // Lane widths, byte size and buffer depth
   localparam logic [2:0] LANES_1 = 3'h1;
   localparam logic [2:0] LANES_2 = 3'h2;
   localparam logic [2:0] LANES_4 = 3'h4;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [1:0] BUF_DEPTH = 2'h2;

   typedef enum logic [2:0] {
      ST_OPCODE = 3'b000,
      ST_ADDR = 3'b001,
      ST_DUMMY = 3'b010,
      ST_DATA = 3'b011,
      ST_IGNORE = 3'b100
   } sfr_state_type;

   typedef struct packed {
      logic ok;
      logic [2:0] addr_lanes;
      logic [2:0] data_lanes;
      logic [3:0] dummy;
   } sfr_cmd_type;

endpackage : sfr_pkg

// [testbench/sfr_host_model.sv]
`timescale 1ns/100ps
module sfr_host_model (
   input wire logic i_clk,
   input wire logic [3:0] i_io_out,
   input wire logic [3:0] i_io_oe_n,
   output logic o_cs_n = 1'b1,
   output logic o_sclk = 1'b0,
   output logic [3:0] o_io_in
);
   logic [3:0] drv = 4'h0;
   logic [3:0] drv_en = 4'h0;
   logic [3:0] idle = 4'h5;
   logic [7:0] rx[$];
   int hiz_bad = 0;
   int drove = 0;
   // Released lines show a changing pattern
   always @(posedge i_clk) idle <= ~idle;
   always_comb for (int i = 0; i < 4; i++) o_io_in[i] = !i_io_oe_n[i] ? i_io_out[i] : drv_en[i] ? drv[i] : idle[i];
   task automatic half();
      repeat (6) @(posedge i_clk);
   endtask : half
   task automatic tick();
      half();
      o_sclk <= 1'b1;
      half();
      o_sclk <= 1'b0;
   endtask : tick
   task automatic shift(input logic [23:0] v, input int n, input int w);
      for (int c = n - 1; c >= 0; c--) begin
         drv <= 4'((v >> (c * w)) & ((1 << w) - 1));
         drv_en <= 4'((1 << w) - 1);
         if (i_io_oe_n !== 4'hF) hiz_bad++;
         tick();
      end
   endtask : shift
   task automatic run(input logic [7:0] op, input logic [23:0] a, input int ow, input int aw, input int dum,
      input int dw, input int nclk);
      logic [7:0] sh;
      int cnt;
      sh = 8'h00;
      cnt = 0;
      hiz_bad = 0;
      drove = 0;
      rx.delete();
      @(posedge i_clk);
      o_cs_n <= 1'b0;
      shift(24'(op), 8 / ow, ow);
      shift(a, 24 / aw, aw);
      drv_en <= 4'h0;
      repeat (dum) begin
         if (i_io_oe_n !== 4'hF) hiz_bad++;
         tick();
      end
      for (int c = 0; c < nclk; c++) begin
         half();
         if (i_io_oe_n !== 4'hF) drove++;
         sh = (sh << dw) | 8'(dw == 1 ? o_io_in[1] : o_io_in & 4'((1 << dw) - 1));
         cnt += dw;
         if (cnt == 8) begin
            rx.push_back(sh);
            cnt = 0;
         end
         o_sclk <= 1'b1;
         half();
         o_sclk <= 1'b0;
      end
      half();
      o_cs_n <= 1'b1;
      repeat (8) @(posedge i_clk);
   endtask : run
endmodule : sfr_host_model

// [testbench/sfr_read_engine_sva.sv]
`timescale 1ns/100ps
module sfr_read_engine_chk #(
   parameter int ADDR_W = 24
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cs_n,
   input wire logic i_sclk,
   input wire logic [3:0] o_io_out,
   input wire logic [3:0] o_io_oe_n,
   input wire logic o_mem_req,
   input wire logic [ADDR_W-1:0] o_mem_addr,
   input wire logic i_mem_gnt,
   input wire logic o_mem_ready
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   chk_idle_hiz: assert property (i_cs_n [*5] |-> o_io_oe_n == 4'hF)
      else $error("lines driven while deselected");
   chk_drive_sel: assert property (o_io_oe_n != 4'hF |-> !$past(i_cs_n, 5))
      else $error("lines driven without a command");
   chk_lane_set: assert property (o_io_oe_n inside {4'hF, 4'hD, 4'hC, 4'h0})
      else $error("illegal lane enable set");
   chk_out_hold: assert property (($stable(i_sclk) && $stable(i_cs_n)) [*5] |->
      $stable(o_io_out) && $stable(o_io_oe_n)) else $error("lines moved without a clock fall");
   chk_rst_quiet: assert property ($fell(i_rst) |-> o_io_oe_n == 4'hF && !o_mem_req && o_mem_ready)
      else $error("wrong values out of reset");
   chk_req_hold: assert property (o_mem_req && !i_mem_gnt |=> o_mem_req && $stable(o_mem_addr))
      else $error("request dropped before grant");
   chk_addr_step: assert property (o_mem_req && i_mem_gnt |=>
      o_mem_addr == ADDR_W'($past(o_mem_addr) + 1'b1)) else $error("address did not step by one");
   chk_idle_noreq: assert property (i_cs_n [*8] |-> !o_mem_req)
      else $error("array read while deselected");
   cover property (!o_mem_ready);
endmodule : sfr_read_engine_chk

bind sfr_read_engine sfr_read_engine_chk #(.ADDR_W(ADDR_W)) chk_i (.i_clk(i_clk), .i_rst(i_rst),
   .i_cs_n(i_cs_n), .i_sclk(i_sclk), .o_io_out(o_io_out), .o_io_oe_n(o_io_oe_n), .o_mem_req(o_mem_req),
   .o_mem_addr(o_mem_addr), .i_mem_gnt(i_mem_gnt), .o_mem_ready(o_mem_ready));

// [testbench/tb.sv]
`timescale 1ns/100ps
module tb;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic cs_n, sclk, req, rdy;
   logic busy = 1'b0, four = 1'b0, quad_en = 1'b0, gnt = 1'b0, mv = 1'b0, full_seen = 1'b0;
   logic [3:0] io_in, io_out, oe_n;
   logic [7:0] cfg = 8'h00;
   logic [7:0] md = 8'h00;
   logic [23:0] maddr;
   int errors = 0;
   int tests_run = 0;
   always #2 i_clk = ~i_clk;
   sfr_read_engine dut (.i_clk(i_clk), .i_rst(i_rst), .i_cs_n(cs_n), .i_sclk(sclk), .i_io_in(io_in),
      .o_io_out(io_out), .o_io_oe_n(oe_n), .i_write_busy(busy), .i_four_line_command_mode(four),
      .i_quad_enable_bit(quad_en), .i_config_reg(cfg), .o_mem_req(req), .o_mem_addr(maddr), .i_mem_gnt(gnt),
      .i_mem_valid(mv), .i_mem_data(md), .o_mem_ready(rdy));
   sfr_host_model host (.i_clk(i_clk), .i_io_out(io_out), .i_io_oe_n(oe_n), .o_cs_n(cs_n), .o_sclk(sclk),
      .o_io_in(io_in));
   function automatic logic [7:0] pat(input logic [23:0] a);
      return a[7:0] ^ a[23:16] ^ 8'h5A;
   endfunction : pat
   // Array grants every other cycle and answers one cycle later
   always @(posedge i_clk) begin
      gnt <= ~gnt;
      if (!rdy) full_seen <= 1'b1;
      if (mv && rdy) mv <= 1'b0;
      if (req && gnt) begin
         mv <= 1'b1;
         md <= pat(maddr);
      end
      if (i_rst) mv <= 1'b0;
   end
   task automatic chk(input logic ok, input string m);
      tests_run++;
      if (ok !== 1'b1) begin
         errors++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask : chk
   task automatic bytes_ok(input logic [23:0] a, input int n);
      chk(host.rx.size() == n, "byte count");
      chk(host.hiz_bad == 0, "line driven before data");
      for (int i = 0; i < n && i < host.rx.size(); i++) chk(host.rx[i] === pat(a + 24'(i)), "data byte");
   endtask : bytes_ok
   task automatic t_read();
      host.run(sfr_pkg::OP_READ, 24'h12_3457, 1, 1, 0, 1, 24);
      bytes_ok(24'h12_3457, 3);
      chk(full_seen === 1'b1, "buffer never filled");
   endtask : t_read
   task automatic t_abort();
      host.run(sfr_pkg::OP_READ, 24'h00_0010, 1, 1, 0, 1, 20);
      bytes_ok(24'h00_0010, 2);
      chk(oe_n === 4'hF, "lines held after deselect");
   endtask : t_abort
   task automatic t_fast();
      host.run(sfr_pkg::OP_FAST_READ, 24'h00_0001, 1, 1, 8, 1, 16);
      bytes_ok(24'h00_0001, 2);
   endtask : t_fast
   task automatic t_dual_out();
      host.run(sfr_pkg::OP_DUAL_OUTPUT_READ, 24'hAB_CDEF, 1, 1, 8, 2, 8);
      bytes_ok(24'hAB_CDEF, 2);
   endtask : t_dual_out
   task automatic t_dual_io();
      for (int k = 0; k < 4; k++) begin
         cfg <= 8'(k << 6);
         host.run(sfr_pkg::OP_DUAL_IO_READ, 24'h31_4159, 1, 2, k[0] ? 8 : 4, 2, 8);
         bytes_ok(24'h31_4159, 2);
      end
   endtask : t_dual_io
   task automatic t_quad();
      quad_en <= 1'b1;
      host.run(sfr_pkg::OP_QUAD_OUTPUT_READ, 24'hFF_FFFE, 1, 1, 8, 4, 8);
      bytes_ok(24'hFF_FFFE, 4);
   endtask : t_quad
   task automatic t_four();
      four <= 1'b1;
      host.run(sfr_pkg::OP_FAST_READ, 24'h45_6789, 4, 4, 4, 4, 6);
      four <= 1'b0;
      bytes_ok(24'h45_6789, 3);
   endtask : t_four
   task automatic t_refuse();
      quad_en <= 1'b0;
      host.run(sfr_pkg::OP_QUAD_OUTPUT_READ, 24'h00_0000, 1, 1, 8, 4, 8);
      chk(host.drove == 0, "quad read answered without enable");
      busy <= 1'b1;
      host.run(sfr_pkg::OP_READ, 24'h00_0000, 1, 1, 0, 1, 16);
      chk(host.drove == 0, "read answered while busy");
      busy <= 1'b0;
      four <= 1'b1;
      host.run(sfr_pkg::OP_READ, 24'h00_0000, 4, 4, 0, 4, 6);
      chk(host.drove == 0, "plain read answered in four-line mode");
      chk(host.hiz_bad == 0, "line driven during refused command");
      four <= 1'b0;
   endtask : t_refuse
   task automatic test_done();
      $display("errors=%0d tests_run=%0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : test_done
   initial begin
      repeat (10) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (3) @(posedge i_clk);
      t_read();
      t_abort();
      t_fast();
      t_dual_out();
      t_dual_io();
      t_quad();
      t_four();
      t_refuse();
      test_done();
   end
   initial begin
      repeat (50000) @(posedge i_clk);
      errors++;
      $display("MISMATCH %0t run timed out", $time);
      test_done();
   end
endmodule : tb
